//--- sbd_bus_mode_regs.sv
// Bus control and wake control register bank with mode substitution
`timescale 1ns/1ns
module sbd_bus_mode_regs (
  input  wire logic                      core_clk,
  input  wire logic                      rst_b,
  input  wire logic                      soft_rst,
  input  wire logic              [6:0]   reg_addr,
  input  wire logic                      reg_wr_en,
  input  wire logic              [7:0]   reg_wr_data,
  input  wire logic                      reg_rd_en,
  input  wire sbd_pkg::sbd_chip_mode_e   chip_mode,
  input  wire logic                      boost_fixed_select,
  input  wire logic                      watchdog_stop_disable_a,
  input  wire logic                      hw_can_mode_we,
  input  wire logic              [1:0]   hw_can_mode_d,
  input  wire logic                      hw_lin_one_mode_we,
  input  wire logic              [1:0]   hw_lin_one_mode_d,
  input  wire logic                      hw_lin_two_mode_we,
  input  wire logic              [1:0]   hw_lin_two_mode_d,
  input  wire logic                      hw_lin_three_mode_we,
  input  wire logic              [1:0]   hw_lin_three_mode_d,
  input  wire logic                      hw_lin_four_mode_we,
  input  wire logic              [1:0]   hw_lin_four_mode_d,
  input  wire logic                      hw_wd_stop_we,
  input  wire logic                      hw_wd_stop_d,
  output logic                   [7:0]   reg_rd_data,
  output logic                           reg_rd_valid,
  output sbd_pkg::sbd_xcvr_mode_e        can_mode_eff,
  output sbd_pkg::sbd_xcvr_mode_e        lin_one_mode_eff,
  output sbd_pkg::sbd_xcvr_mode_e        lin_two_mode_eff,
  output sbd_pkg::sbd_xcvr_mode_e        lin_three_mode_eff,
  output sbd_pkg::sbd_xcvr_mode_e        lin_four_mode_eff,
  output logic                           lin_slope_control_off,
  output logic                           lin_low_slope_select,
  output logic                           lin_transmit_timeout_enable,
  output sbd_pkg::sbd_boost_level_e      boost_level,
  output logic                           cyclic_timer_wake_enable,
  output logic                           watchdog_stop_off
);
  import sbd_pkg::*;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic sel_first;
  logic sel_second;
  logic sel_wake;
  logic wr_first;
  logic wr_second;
  logic wr_wake;

  assign sel_first  = (reg_addr == BUS_CONTROL_FIRST_ADDR);
  assign sel_second = (reg_addr == BUS_CONTROL_SECOND_ADDR);
  assign sel_wake   = (reg_addr == WAKE_INPUT_CONTROL_ADDR);
  assign wr_first   = reg_wr_en && sel_first;
  assign wr_second  = reg_wr_en && sel_second;
  assign wr_wake    = reg_wr_en && sel_wake;

  // ****************************************************************
  // First bus control fields
  // ****************************************************************
  logic       lin_fast_prog;
  logic       lin_low_slope;
  logic       lin_timeout;
  logic [1:0] lin_channel_one_mode;
  logic [1:0] can_mode;

  sbd_field #(
    .W   (1),
    .RST (BUS_CONTROL_FIRST_RST[LIN_FAST_PROG_BIT])
  ) u_lin_fast_prog (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .soft_rst (soft_rst),
    .host_we  (wr_first),
    .host_d   (reg_wr_data[LIN_FAST_PROG_BIT]),
    .hw_we    (1'b0),
    .hw_d     (1'b0),
    .q        (lin_fast_prog)
  );

  sbd_field #(
    .W   (1),
    .RST (BUS_CONTROL_FIRST_RST[LIN_LOW_SLOPE_BIT])
  ) u_lin_low_slope (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .soft_rst (soft_rst),
    .host_we  (wr_first),
    .host_d   (reg_wr_data[LIN_LOW_SLOPE_BIT]),
    .hw_we    (1'b0),
    .hw_d     (1'b0),
    .q        (lin_low_slope)
  );

  sbd_field #(
    .W   (1),
    .RST (BUS_CONTROL_FIRST_RST[LIN_TIMEOUT_BIT])
  ) u_lin_timeout (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .soft_rst (soft_rst),
    .host_we  (wr_first),
    .host_d   (reg_wr_data[LIN_TIMEOUT_BIT]),
    .hw_we    (1'b0),
    .hw_d     (1'b0),
    .q        (lin_timeout)
  );

  sbd_field #(
    .W   (2),
    .RST (BUS_CONTROL_FIRST_RST[LIN_ONE_MSB:LIN_ONE_LSB])
  ) u_lin_one (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .soft_rst (soft_rst),
    .host_we  (wr_first),
    .host_d   (reg_wr_data[LIN_ONE_MSB:LIN_ONE_LSB]),
    .hw_we    (hw_lin_one_mode_we),
    .hw_d     (hw_lin_one_mode_d),
    .q        (lin_channel_one_mode)
  );

  sbd_field #(
    .W   (2),
    .RST (BUS_CONTROL_FIRST_RST[CAN_MSB:CAN_LSB])
  ) u_can (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .soft_rst (soft_rst),
    .host_we  (wr_first),
    .host_d   (reg_wr_data[CAN_MSB:CAN_LSB]),
    .hw_we    (hw_can_mode_we),
    .hw_d     (hw_can_mode_d),
    .q        (can_mode)
  );

  // ****************************************************************
  // Second bus control fields
  // ****************************************************************
  logic [1:0] lin_channel_four_mode;
  logic       boost_high_level_select;
  logic [1:0] lin_channel_three_mode;
  logic [1:0] lin_channel_two_mode;

  sbd_field #(
    .W   (2),
    .RST (BUS_CONTROL_SECOND_RST[LIN_FOUR_MSB:LIN_FOUR_LSB])
  ) u_lin_four (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .soft_rst (soft_rst),
    .host_we  (wr_second),
    .host_d   (reg_wr_data[LIN_FOUR_MSB:LIN_FOUR_LSB]),
    .hw_we    (hw_lin_four_mode_we),
    .hw_d     (hw_lin_four_mode_d),
    .q        (lin_channel_four_mode)
  );

  sbd_field #(
    .W   (1),
    .RST (BUS_CONTROL_SECOND_RST[BOOST_HIGH_BIT])
  ) u_boost_high (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .soft_rst (soft_rst),
    .host_we  (wr_second),
    .host_d   (reg_wr_data[BOOST_HIGH_BIT]),
    .hw_we    (1'b0),
    .hw_d     (1'b0),
    .q        (boost_high_level_select)
  );

  sbd_field #(
    .W   (2),
    .RST (BUS_CONTROL_SECOND_RST[LIN_THREE_MSB:LIN_THREE_LSB])
  ) u_lin_three (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .soft_rst (soft_rst),
    .host_we  (wr_second),
    .host_d   (reg_wr_data[LIN_THREE_MSB:LIN_THREE_LSB]),
    .hw_we    (hw_lin_three_mode_we),
    .hw_d     (hw_lin_three_mode_d),
    .q        (lin_channel_three_mode)
  );

  sbd_field #(
    .W   (2),
    .RST (BUS_CONTROL_SECOND_RST[LIN_TWO_MSB:LIN_TWO_LSB])
  ) u_lin_two (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .soft_rst (soft_rst),
    .host_we  (wr_second),
    .host_d   (reg_wr_data[LIN_TWO_MSB:LIN_TWO_LSB]),
    .hw_we    (hw_lin_two_mode_we),
    .hw_d     (hw_lin_two_mode_d),
    .q        (lin_channel_two_mode)
  );

  // ****************************************************************
  // Wake input control fields
  // ****************************************************************
  logic timer_wake;
  logic wd_stop_b;

  sbd_field #(
    .W   (1),
    .RST (WAKE_INPUT_CONTROL_RST[TIMER_WAKE_BIT])
  ) u_timer_wake (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .soft_rst (soft_rst),
    .host_we  (wr_wake),
    .host_d   (reg_wr_data[TIMER_WAKE_BIT]),
    .hw_we    (1'b0),
    .hw_d     (1'b0),
    .q        (timer_wake)
  );

  sbd_field #(
    .W   (1),
    .RST (WAKE_INPUT_CONTROL_RST[WD_STOP_BIT])
  ) u_wd_stop (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .soft_rst (soft_rst),
    .host_we  (wr_wake),
    .host_d   (reg_wr_data[WD_STOP_BIT]),
    .hw_we    (hw_wd_stop_we),
    .hw_d     (hw_wd_stop_d),
    .q        (wd_stop_b)
  );

  // ****************************************************************
  // Effective transceiver modes
  // ****************************************************************
  logic low_power;

  // Restart is left out on purpose: the stored mode drives there
  assign low_power = (chip_mode == SBD_CHIP_STOP) ||
                     (chip_mode == SBD_CHIP_SLEEP);

  sbd_mode_sub u_can_eff (
    .core_clk    (core_clk),
    .rst_b       (rst_b),
    .low_power   (low_power),
    .stored_mode (can_mode),
    .eff_mode    (can_mode_eff)
  );

  sbd_mode_sub u_lin_one_eff (
    .core_clk    (core_clk),
    .rst_b       (rst_b),
    .low_power   (low_power),
    .stored_mode (lin_channel_one_mode),
    .eff_mode    (lin_one_mode_eff)
  );

  sbd_mode_sub u_lin_two_eff (
    .core_clk    (core_clk),
    .rst_b       (rst_b),
    .low_power   (low_power),
    .stored_mode (lin_channel_two_mode),
    .eff_mode    (lin_two_mode_eff)
  );

  sbd_mode_sub u_lin_three_eff (
    .core_clk    (core_clk),
    .rst_b       (rst_b),
    .low_power   (low_power),
    .stored_mode (lin_channel_three_mode),
    .eff_mode    (lin_three_mode_eff)
  );

  sbd_mode_sub u_lin_four_eff (
    .core_clk    (core_clk),
    .rst_b       (rst_b),
    .low_power   (low_power),
    .stored_mode (lin_channel_four_mode),
    .eff_mode    (lin_four_mode_eff)
  );

  // ****************************************************************
  // Control outputs
  // ****************************************************************
  sbd_boost_level_e boost_next;
  logic             wd_stop_next;

  assign boost_next   = boost_fixed_select      ? SBD_BOOST_FIXED :
                        boost_high_level_select ? SBD_BOOST_10V   :
                        SBD_BOOST_8V;
  // Either stop-mode bit deactivates the watchdog
  assign wd_stop_next = wd_stop_b || watchdog_stop_disable_a;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      lin_slope_control_off       <= 1'b0;
      lin_low_slope_select        <= 1'b0;
      lin_transmit_timeout_enable <= 1'b0;
      boost_level                 <= SBD_BOOST_8V;
      cyclic_timer_wake_enable    <= 1'b0;
      watchdog_stop_off           <= 1'b0;
    end else begin
      lin_slope_control_off       <= lin_fast_prog;
      lin_low_slope_select        <= lin_low_slope;
      lin_transmit_timeout_enable <= lin_timeout;
      boost_level                 <= boost_next;
      cyclic_timer_wake_enable    <= timer_wake;
      watchdog_stop_off           <= wd_stop_next;
    end
  end

  // ****************************************************************
  // Read back
  // ****************************************************************
  logic [7:0] rd_first;
  logic [7:0] rd_second;
  logic [7:0] rd_wake;
  logic [7:0] rd_mux;

  // Reserved positions are constant zero, so writes to them vanish
  assign rd_first  = {lin_fast_prog, lin_low_slope, lin_timeout,
                      lin_channel_one_mode, 1'b0, can_mode};
  assign rd_second = {lin_channel_four_mode, boost_high_level_select,
                      lin_channel_three_mode, 1'b0,
                      lin_channel_two_mode};
  assign rd_wake   = {1'b0, timer_wake, 3'h0, wd_stop_b, 2'h0};
  assign rd_mux    = sel_first  ? rd_first  :
                     sel_second ? rd_second :
                     sel_wake   ? rd_wake   : READ_IDLE;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      reg_rd_data  <= READ_IDLE;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rd_data <= rd_mux;
      end
    end
  end
endmodule : sbd_bus_mode_regs

//--- sbd_pkg.sv
// Constants and types for the transceiver mode register bank
// ****************************************************************
// ****************************************************************
package sbd_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [6:0] BUS_CONTROL_FIRST_ADDR  = 7'h04;
  localparam logic [6:0] BUS_CONTROL_SECOND_ADDR = 7'h05;
  localparam logic [6:0] WAKE_INPUT_CONTROL_ADDR = 7'h06;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] BUS_CONTROL_FIRST_RST  = 8'h20;
  localparam logic [7:0] BUS_CONTROL_SECOND_RST = 8'h00;
  localparam logic [7:0] WAKE_INPUT_CONTROL_RST = 8'h00;
  localparam logic [7:0] READ_IDLE              = 8'h00;

  // ****************************************************************
  // Field positions, first bus control
  // ****************************************************************
  localparam int LIN_FAST_PROG_BIT   = 7;
  localparam int LIN_LOW_SLOPE_BIT   = 6;
  localparam int LIN_TIMEOUT_BIT     = 5;
  localparam int LIN_ONE_MSB         = 4;
  localparam int LIN_ONE_LSB         = 3;
  localparam int CAN_MSB             = 1;
  localparam int CAN_LSB             = 0;

  // ****************************************************************
  // Field positions, second bus control and wake control
  // ****************************************************************
  localparam int LIN_FOUR_MSB        = 7;
  localparam int LIN_FOUR_LSB        = 6;
  localparam int BOOST_HIGH_BIT      = 5;
  localparam int LIN_THREE_MSB       = 4;
  localparam int LIN_THREE_LSB       = 3;
  localparam int LIN_TWO_MSB         = 1;
  localparam int LIN_TWO_LSB         = 0;
  localparam int TIMER_WAKE_BIT      = 6;
  localparam int WD_STOP_BIT         = 2;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    SBD_XCVR_OFF     = 2'h0,
    SBD_XCVR_WAKE    = 2'h1,
    SBD_XCVR_RX_ONLY = 2'h2,
    SBD_XCVR_NORMAL  = 2'h3
  } sbd_xcvr_mode_e;

  typedef enum logic [1:0] {
    SBD_CHIP_NORMAL  = 2'h0,
    SBD_CHIP_STOP    = 2'h1,
    SBD_CHIP_SLEEP   = 2'h3,
    SBD_CHIP_RESTART = 2'h2
  } sbd_chip_mode_e;

  typedef enum logic [1:0] {
    SBD_BOOST_8V    = 2'h0,
    SBD_BOOST_10V   = 2'h1,
    SBD_BOOST_FIXED = 2'h2
  } sbd_boost_level_e;

endpackage : sbd_pkg

//--- sbd_field.sv
// One stored register field with host write and hardware update
`timescale 1ns/1ns
module sbd_field #(
  parameter int            W   = 1,
  parameter logic [W-1:0]  RST = '0
) (
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  input  wire logic         soft_rst,
  input  wire logic         host_we,
  input  wire logic [W-1:0] host_d,
  input  wire logic         hw_we,
  input  wire logic [W-1:0] hw_d,
  output logic      [W-1:0] q
);
  import sbd_pkg::*;

  logic [W-1:0] q_next;

  // Internal update beats a host write in the same cycle
  assign q_next = hw_we   ? hw_d   :
                  host_we ? host_d : q;

  always_ff @(posedge core_clk) begin
    if (!rst_b || soft_rst) begin
      q <= RST;
    end else begin
      q <= q_next;
    end
  end
endmodule : sbd_field

//--- sbd_mode_sub.sv
// Effective transceiver mode from stored field and chip mode
`timescale 1ns/1ns
module sbd_mode_sub (
  input  wire logic                   core_clk,
  input  wire logic                   rst_b,
  input  wire logic                   low_power,
  input  wire logic           [1:0]   stored_mode,
  output sbd_pkg::sbd_xcvr_mode_e     eff_mode
);
  import sbd_pkg::*;

  logic           is_normal;
  sbd_xcvr_mode_e eff_next;

  assign is_normal = (stored_mode == SBD_XCVR_NORMAL);
  // Stored bits are only read here, so Normal restores them directly
  assign eff_next  = (low_power && is_normal) ? SBD_XCVR_WAKE :
                     sbd_xcvr_mode_e'(stored_mode);

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      eff_mode <= SBD_XCVR_OFF;
    end else begin
      eff_mode <= eff_next;
    end
  end
endmodule : sbd_mode_sub

//--- sbd_bus_mode_regs_props.sv
// Checker for the bus and wake control register bank
`timescale 1ns/1ns
module sbd_bus_mode_regs_props (
  input wire logic                      core_clk,
  input wire logic                      rst_b,
  input wire logic                      soft_rst,
  input wire logic              [6:0]   reg_addr,
  input wire logic                      reg_wr_en,
  input wire logic              [7:0]   reg_wr_data,
  input wire logic                      reg_rd_en,
  input wire sbd_pkg::sbd_chip_mode_e   chip_mode,
  input wire logic                      boost_fixed_select,
  input wire logic                      watchdog_stop_disable_a,
  input wire logic                      hw_can_mode_we,
  input wire logic              [1:0]   hw_can_mode_d,
  input wire logic              [7:0]   reg_rd_data,
  input wire logic                      reg_rd_valid,
  input wire sbd_pkg::sbd_xcvr_mode_e   can_mode_eff,
  input wire sbd_pkg::sbd_xcvr_mode_e   lin_one_mode_eff,
  input wire sbd_pkg::sbd_xcvr_mode_e   lin_two_mode_eff,
  input wire sbd_pkg::sbd_xcvr_mode_e   lin_three_mode_eff,
  input wire sbd_pkg::sbd_xcvr_mode_e   lin_four_mode_eff,
  input wire logic                      lin_slope_control_off,
  input wire logic                      lin_low_slope_select,
  input wire logic                      lin_transmit_timeout_enable,
  input wire sbd_pkg::sbd_boost_level_e boost_level,
  input wire logic                      watchdog_stop_off
);
  import sbd_pkg::*;
  // *********************
  // Helpers
  // *********************
  wire logic       low_pwr  = (chip_mode == SBD_CHIP_STOP) ||
                              (chip_mode == SBD_CHIP_SLEEP);
  wire logic       wr_first = reg_wr_en && !soft_rst &&
                              (reg_addr == BUS_CONTROL_FIRST_ADDR);
  wire logic [2:0] wr_slope = reg_wr_data[7:5];
  wire logic [1:0] wr_can   = reg_wr_data[1:0];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // *********************
  // Properties
  // *********************
  chk_slope_bits_follow: assert property (
    wr_first |=> ##1 {lin_slope_control_off, lin_low_slope_select,
    lin_transmit_timeout_enable} == $past(wr_slope, 2))
    else $error("slope bits do not follow the write");
  chk_can_mode_write: assert property (
    wr_first && !hw_can_mode_we ##1 chip_mode == SBD_CHIP_NORMAL
    |=> can_mode_eff == $past(wr_can, 2))
    else $error("can mode does not follow the write");
  chk_hw_update_wins: assert property (
    hw_can_mode_we && !soft_rst ##1 chip_mode == SBD_CHIP_NORMAL
    |=> can_mode_eff == $past(hw_can_mode_d, 2))
    else $error("hardware can mode update lost");
  chk_can_low_power: assert property (
    low_pwr |=> can_mode_eff != SBD_XCVR_NORMAL)
    else $error("can runs normal in low power");
  chk_lin_low_power: assert property (
    low_pwr |=> lin_one_mode_eff != SBD_XCVR_NORMAL &&
    lin_two_mode_eff != SBD_XCVR_NORMAL &&
    lin_three_mode_eff != SBD_XCVR_NORMAL &&
    lin_four_mode_eff != SBD_XCVR_NORMAL)
    else $error("lin runs normal in low power");
  chk_bus_rsvd_zero: assert property (
    reg_rd_en && reg_addr != WAKE_INPUT_CONTROL_ADDR
    |=> reg_rd_valid && !reg_rd_data[2])
    else $error("reserved bus bit reads one");
  chk_wake_rsvd_zero: assert property (
    reg_rd_en && reg_addr == WAKE_INPUT_CONTROL_ADDR
    |=> reg_rd_valid && (reg_rd_data & 8'hBB) == 8'h00)
    else $error("reserved wake bits read one");
  chk_unmapped_idle: assert property (
    reg_rd_en && (reg_addr < BUS_CONTROL_FIRST_ADDR ||
    reg_addr > WAKE_INPUT_CONTROL_ADDR) |=> reg_rd_data == READ_IDLE)
    else $error("unmapped read not zero");
  chk_boost_fixed_wins: assert property (
    boost_fixed_select |=> boost_level == SBD_BOOST_FIXED)
    else $error("fixed boost level not taken");
  chk_wd_stop_or: assert property (
    watchdog_stop_disable_a |=> watchdog_stop_off)
    else $error("watchdog stop disable ignored");
endmodule : sbd_bus_mode_regs_props

bind sbd_bus_mode_regs sbd_bus_mode_regs_props u_props (
  .core_clk(core_clk), .rst_b(rst_b), .soft_rst(soft_rst),
  .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
  .reg_rd_en(reg_rd_en), .chip_mode(chip_mode),
  .boost_fixed_select(boost_fixed_select),
  .watchdog_stop_disable_a(watchdog_stop_disable_a),
  .hw_can_mode_we(hw_can_mode_we), .hw_can_mode_d(hw_can_mode_d),
  .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
  .can_mode_eff(can_mode_eff), .lin_one_mode_eff(lin_one_mode_eff),
  .lin_two_mode_eff(lin_two_mode_eff),
  .lin_three_mode_eff(lin_three_mode_eff),
  .lin_four_mode_eff(lin_four_mode_eff),
  .lin_slope_control_off(lin_slope_control_off),
  .lin_low_slope_select(lin_low_slope_select),
  .lin_transmit_timeout_enable(lin_transmit_timeout_enable),
  .boost_level(boost_level), .watchdog_stop_off(watchdog_stop_off)
);

//--- sbd_host_model.sv
// Host controller model: register accesses and chip mode requests
`timescale 1ns/1ns
module sbd_host_model (
  input  wire logic                   core_clk,
  output logic                  [6:0] reg_addr,
  output logic                        reg_wr_en,
  output logic                  [7:0] reg_wr_data,
  output logic                        reg_rd_en,
  output sbd_pkg::sbd_chip_mode_e     chip_mode,
  input  wire logic             [7:0] reg_rd_data,
  input  wire logic                   reg_rd_valid
);
  import sbd_pkg::*;
  initial begin
    reg_addr    = 7'h00;
    reg_wr_en   = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en   = 1'b0;
    chip_mode   = SBD_CHIP_NORMAL;
  end
  // Released lines show inverted data, never the last value
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr    <= a;
    reg_wr_data <= d;
    reg_wr_en   <= 1'b1;
    @(posedge core_clk);
    reg_wr_en   <= 1'b0;
    reg_addr    <= ~a;
    reg_wr_data <= ~d;
  endtask : wr
  // No valid strobe gives unknown data back
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_rd_en <= 1'b1;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
    reg_addr  <= ~a;
    #1;
    d = reg_rd_valid ? reg_rd_data : 8'hXX;
  endtask : rd
  task automatic set_mode(input sbd_chip_mode_e m);
    @(posedge core_clk);
    chip_mode <= m;
  endtask : set_mode
  task automatic go_sleep(input logic [7:0] first_val);
    wr(BUS_CONTROL_FIRST_ADDR, {first_val[7:2], SBD_XCVR_WAKE});
    set_mode(SBD_CHIP_SLEEP);
  endtask : go_sleep
endmodule : sbd_host_model

//--- sbd_bus_mode_regs_tb.sv
// Self-checking bench for the bus and wake control register bank
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("wrong value at %0t got %h expected %h", $time, got, exp); \
    end \
  end
module sbd_bus_mode_regs_tb;
  import sbd_pkg::*;
  typedef struct packed {logic [6:0] a; logic [7:0] w; logic [7:0] r;} sbd_row_s;
  logic core_clk = 1'b0;
  logic rst_b, soft_rst, fixed_sel, wd_a, hw_wd_we, hw_wd_d, rd_valid;
  logic slope_off, low_slope, tx_to, timer_en, wd_off;
  logic [4:0] hw_we;
  logic [1:0] hw_d;
  logic [6:0] addr;
  logic [7:0] wdata, rdata, d;
  logic wr_en, rd_en;
  int miscompares = 0;
  int samples_checked = 0;
  sbd_chip_mode_e chip_mode;
  sbd_xcvr_mode_e can_eff, lin_one_eff, lin_two_eff;
  sbd_xcvr_mode_e lin_three_eff, lin_four_eff;
  sbd_boost_level_e boost;
  sbd_row_s rows [8] = '{{7'h04, 8'hFF, 8'hFB}, {7'h04, 8'h5B, 8'h5B},
    {7'h05, 8'hFF, 8'hFB}, {7'h05, 8'h6A, 8'h6A}, {7'h06, 8'hFF, 8'h44},
    {7'h06, 8'hB8, 8'h00}, {7'h07, 8'hFF, 8'h00}, {7'h03, 8'h5A, 8'h00}};
  always #5 core_clk = ~core_clk;
  sbd_host_model host (.core_clk(core_clk), .reg_addr(addr), .reg_wr_en(wr_en),
    .reg_wr_data(wdata), .reg_rd_en(rd_en), .chip_mode(chip_mode),
    .reg_rd_data(rdata), .reg_rd_valid(rd_valid));
  sbd_bus_mode_regs dut (.core_clk(core_clk), .rst_b(rst_b),
    .soft_rst(soft_rst), .reg_addr(addr), .reg_wr_en(wr_en),
    .reg_wr_data(wdata), .reg_rd_en(rd_en), .chip_mode(chip_mode),
    .boost_fixed_select(fixed_sel), .watchdog_stop_disable_a(wd_a),
    .hw_can_mode_we(hw_we[0]), .hw_can_mode_d(hw_d),
    .hw_lin_one_mode_we(hw_we[1]), .hw_lin_one_mode_d(hw_d),
    .hw_lin_two_mode_we(hw_we[2]), .hw_lin_two_mode_d(hw_d),
    .hw_lin_three_mode_we(hw_we[3]), .hw_lin_three_mode_d(hw_d),
    .hw_lin_four_mode_we(hw_we[4]), .hw_lin_four_mode_d(hw_d),
    .hw_wd_stop_we(hw_wd_we), .hw_wd_stop_d(hw_wd_d),
    .reg_rd_data(rdata), .reg_rd_valid(rd_valid), .can_mode_eff(can_eff),
    .lin_one_mode_eff(lin_one_eff), .lin_two_mode_eff(lin_two_eff),
    .lin_three_mode_eff(lin_three_eff), .lin_four_mode_eff(lin_four_eff),
    .lin_slope_control_off(slope_off), .lin_low_slope_select(low_slope),
    .lin_transmit_timeout_enable(tx_to), .boost_level(boost),
    .cyclic_timer_wake_enable(timer_en), .watchdog_stop_off(wd_off));
  // *********************
  // Shared tasks
  // *********************
  task automatic settle();
    repeat (3) @(posedge core_clk);
    #1;
  endtask : settle
  task automatic check_eff(input sbd_xcvr_mode_e m);
    `CHK(can_eff, m)
    `CHK({lin_one_eff, lin_two_eff}, {2{m}})
    `CHK({lin_three_eff, lin_four_eff}, {2{m}})
  endtask : check_eff
  task automatic check_defaults();
    host.rd(BUS_CONTROL_FIRST_ADDR, d);
    `CHK(d, BUS_CONTROL_FIRST_RST)
    host.rd(BUS_CONTROL_SECOND_ADDR, d);
    `CHK(d, BUS_CONTROL_SECOND_RST)
    host.rd(WAKE_INPUT_CONTROL_ADDR, d);
    `CHK(d, WAKE_INPUT_CONTROL_RST)
  endtask : check_defaults
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  // Generous bound: the sequence needs about 130 cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    give_verdict();
  end
  // *********************
  // Main sequence
  // *********************
  initial begin
    rst_b = 1'b0;
    soft_rst = 1'b0;
    fixed_sel = 1'b0;
    wd_a = 1'b0;
    hw_we = 5'h00;
    hw_d = 2'h0;
    hw_wd_we = 1'b0;
    hw_wd_d = 1'b0;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    check_defaults();
    foreach (rows[i]) begin
      host.wr(rows[i].a, rows[i].w);
      host.rd(rows[i].a, d);
      `CHK(d, rows[i].r)
    end
    @(posedge core_clk);
    soft_rst <= 1'b1;
    @(posedge core_clk);
    soft_rst <= 1'b0;
    check_defaults();
    host.wr(BUS_CONTROL_FIRST_ADDR, 8'h1B);
    host.wr(BUS_CONTROL_SECOND_ADDR, 8'hDB);
    settle();
    check_eff(SBD_XCVR_NORMAL);
    host.set_mode(SBD_CHIP_STOP);
    settle();
    check_eff(SBD_XCVR_WAKE);
    host.rd(BUS_CONTROL_FIRST_ADDR, d);
    `CHK(d, 8'h1B)
    host.set_mode(SBD_CHIP_NORMAL);
    settle();
    check_eff(SBD_XCVR_NORMAL);
    host.wr(BUS_CONTROL_FIRST_ADDR, 8'h1A);
    host.set_mode(SBD_CHIP_STOP);
    settle();
    `CHK(can_eff, SBD_XCVR_RX_ONLY)
    // Restart is not a low-power mode, stored codes pass
    host.set_mode(SBD_CHIP_RESTART);
    settle();
    `CHK({can_eff, lin_four_eff}, {SBD_XCVR_RX_ONLY, SBD_XCVR_NORMAL})
    host.go_sleep(8'h1B);
    settle();
    `CHK({can_eff, lin_four_eff}, {SBD_XCVR_WAKE, SBD_XCVR_WAKE})
    host.set_mode(SBD_CHIP_NORMAL);
    // Hardware update and host write land on the same edge
    fork
      host.wr(BUS_CONTROL_FIRST_ADDR, 8'h1B);
      begin
        @(posedge core_clk);
        hw_we <= 5'h1F;
        hw_d <= 2'h2;
        @(posedge core_clk);
        hw_we <= 5'h00;
      end
    join
    settle();
    check_eff(SBD_XCVR_RX_ONLY);
    host.rd(BUS_CONTROL_FIRST_ADDR, d);
    `CHK(d, 8'h12)
    host.rd(BUS_CONTROL_SECOND_ADDR, d);
    `CHK(d, 8'h92)
    host.wr(BUS_CONTROL_FIRST_ADDR, 8'hC0);
    host.wr(BUS_CONTROL_SECOND_ADDR, 8'h20);
    settle();
    `CHK({slope_off, low_slope, tx_to}, 3'b110)
    `CHK(boost, SBD_BOOST_10V)
    @(posedge core_clk);
    fixed_sel <= 1'b1;
    settle();
    `CHK(boost, SBD_BOOST_FIXED)
    @(posedge core_clk);
    fixed_sel <= 1'b0;
    host.wr(BUS_CONTROL_SECOND_ADDR, 8'h00);
    settle();
    `CHK(boost, SBD_BOOST_8V)
    @(posedge core_clk);
    wd_a <= 1'b1;
    settle();
    `CHK(wd_off, 1'b1)
    @(posedge core_clk);
    wd_a <= 1'b0;
    hw_wd_we <= 1'b1;
    hw_wd_d <= 1'b1;
    @(posedge core_clk);
    hw_wd_we <= 1'b0;
    settle();
    `CHK(wd_off, 1'b1)
    host.rd(WAKE_INPUT_CONTROL_ADDR, d);
    `CHK(d, 8'h04)
    host.wr(WAKE_INPUT_CONTROL_ADDR, 8'h40);
    settle();
    `CHK({wd_off, timer_en}, 2'b01)
    give_verdict();
  end
endmodule : sbd_bus_mode_regs_tb
